// file: rail_strap_limit.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - After power-up a 10 uA source is driven out of the strap pin and the resulting voltage is measured.
// - The decoded address is caught once at start-up and then held regardless of the strap pin.
// - In dual mode the main rail gets an even code 0000 to 1100 and the auxiliary rail that code plus one.
// - Dual strap resistances 10k to 165k map to main codes 0000, 0010 up to 1100.
// - With the auxiliary boot strap tied high the auxiliary rail leaves the bus and the single table applies.
// - Single strap resistances 10k to 220k map to consecutive codes 0000 through 1000.
// - The 100 percent trip rises only after the sink current stays above 10 uA for 50 us.
// - The 150 percent trip rises at once when the sink current exceeds 15 uA.
// - During soft-start each phase is checked for overcurrent on its own differential sense.
module rail_strap_limit
   import strap_pkg::*;
(
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // Strap inputs and source control
   input  wire logic [7:0]         address_strap_pin,
   input  wire logic               aux_boot_strap,
   output logic                    strap_source_en,
   // Current limit and phase sense
   input  wire logic [7:0]         limit_sense_current,
   input  wire logic               soft_start,
   input  wire logic [PHASES*8-1:0] phase_sense_positive,
   input  wire logic [PHASES*8-1:0] phase_sense_negative,
   // Results
   output logic [3:0]              main_addr,
   output logic [3:0]              aux_addr,
   output logic                    aux_enabled,
   output logic                    trip_100,
   output logic                    trip_150,
   output logic [PHASES-1:0]       phase_oc,
   output logic                    irq
);
   strap_if              sres ();
   logic [QCNT_W-1:0]    qual_cnt;
   logic                 over10;
   logic                 over150;
   logic [EV_W-1:0]      status;
   logic [EV_W-1:0]      mask;
   logic [EV_W-1:0]      events;
   logic [7:0]           oc_limit;
   logic                 latched_d;
   logic [7:0]           aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;
   logic                 aw_full;
   logic                 w_full;
   logic                 do_write;
   logic                 wr_stat;
   logic                 wr_mask;
   logic                 wr_limit;
   logic [PHASES-1:0]    next_phase_oc;

   strap_decoder strap_decoder_inst (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .strap_code     (address_strap_pin),
      .aux_boot_strap (aux_boot_strap),
      .res            (sres)
   );

   // ==========================================================
   // Address outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_source_en <= 1'b1;
         main_addr       <= 4'h0;
         aux_addr        <= 4'h1;
         aux_enabled     <= 1'b0;
         latched_d       <= 1'b0;
      end else begin
         strap_source_en <= sres.source_en;
         main_addr       <= sres.main_addr;
         aux_addr        <= sres.aux_addr;
         aux_enabled     <= sres.latched && !sres.single_mode;
         latched_d       <= sres.latched;
      end
   end

   // ==========================================================
   // Total current limit
   assign over10  = limit_sense_current > LIM100_UA;
   assign over150 = limit_sense_current > LIM150_UA;

   // The count stops at its end value, so a long overload cannot wrap and drop the trip.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         qual_cnt <= '0;
      end else if (!over10) begin
         qual_cnt <= '0;
      end else if (qual_cnt != QCNT_W'(QUAL_CYC)) begin
         qual_cnt <= qual_cnt + QCNT_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trip_100 <= 1'b0;
         trip_150 <= 1'b0;
      end else begin
         trip_100 <= over10 && (qual_cnt >= QCNT_W'(QUAL_CYC - 1));
         trip_150 <= over150;
      end
   end

   // ==========================================================
   // Per-phase overcurrent, only meaningful while soft-start runs.
   for (genvar p = 0; p < PHASES; p++) begin : g_phase
      logic [8:0] diff;
      assign diff = {1'b0, phase_sense_positive[p*8 +: 8]}
                  - {1'b0, phase_sense_negative[p*8 +: 8]};
      assign next_phase_oc[p] = soft_start && !diff[8] && (diff[7:0] > oc_limit);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_oc <= '0;
      end else begin
         phase_oc <= next_phase_oc;
      end
   end

   // ==========================================================
   // Interrupt status: a new event beats a clear in the same cycle.
   assign events[EV_TRIP100] = over10 && (qual_cnt == QCNT_W'(QUAL_CYC - 1));
   assign events[EV_TRIP150] = over150 && !trip_150;
   assign events[EV_PHASEOC] = |next_phase_oc && !(|phase_oc);
   assign events[EV_LATCHED] = sres.latched && !latched_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
      end else if (wr_stat) begin
         status <= (status & ~w_data[EV_W-1:0]) | events;
      end else begin
         status <= status | events;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end

   // ==========================================================
   // AXI4-Lite write path
   assign do_write = aw_full && w_full && !s_axi_bvalid;

   // ==========================================================
   // Register decode
   // Every writable field sits in byte lane 0, so a write without that lane changes nothing.
   function automatic logic lane0_hit(input logic [7:0] addr, input logic [7:0] off,
                                      input logic [3:0] strb);
      return addr == off && strb[0];
   endfunction : lane0_hit

   function automatic logic writable(input logic [7:0] addr);
      return addr == INT_STAT || addr == INT_MASK || addr == OC_LIMIT;
   endfunction : writable

   assign wr_stat  = do_write && lane0_hit(aw_addr, INT_STAT, w_strb);
   assign wr_mask  = do_write && lane0_hit(aw_addr, INT_MASK, w_strb);
   assign wr_limit = do_write && lane0_hit(aw_addr, OC_LIMIT, w_strb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            aw_full       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_full       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bresp  <= writable(aw_addr) ? RESP_OKAY : RESP_SLV;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask     <= '0;
         oc_limit <= OC_RESET;
      end else begin
         if (wr_mask) mask <= w_data[EV_W-1:0];
         if (wr_limit) oc_limit <= w_data[7:0];
      end
   end

   // ==========================================================
   // AXI4-Lite read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_INFO: s_axi_rdata <= {21'h0, aux_enabled, sres.single_mode, sres.latched,
                                       aux_addr, main_addr};
            INT_STAT:  s_axi_rdata <= {28'h0, status};
            INT_MASK:  s_axi_rdata <= {28'h0, mask};
            OC_LIMIT:  s_axi_rdata <= {24'h0, oc_limit};
            LIVE_STAT: s_axi_rdata <= {25'h0, phase_oc, trip_150, trip_100};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLV;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence held_over;
      over10 [*8];
   endsequence

   sequence latch_edge;
      sres.latched && !latched_d;
   endsequence

   sequence latch_seen;
      latched_d && !strap_source_en;
   endsequence

   source_on_a: assert property (!sres.latched |=> strap_source_en)
      else $error("strap source off before latch");
   addr_hold_a: assert property (latched_d |=> $stable(main_addr) && $stable(aux_addr))
      else $error("latched address changed");
   dual_pair_a: assert property (aux_enabled |-> !main_addr[0]
                                 && aux_addr == (main_addr | 4'h1))
      else $error("dual address pair wrong");
   dual_range_a: assert property (aux_enabled |-> main_addr <= 4'hC)
      else $error("dual main address out of range");
   single_mode_a: assert property (latched_d && sres.single_mode |-> !aux_enabled)
      else $error("aux rail present in single mode");
   single_range_a: assert property (latched_d && sres.single_mode |-> main_addr <= 4'h8)
      else $error("single address out of range");
   trip_qual_a: assert property ($rose(trip_100) |-> $past(qual_cnt) == QCNT_W'(QUAL_CYC - 1))
      else $error("100 percent trip without full qualification");
   trip_early_a: assert property (held_over ##1 !trip_100 |-> qual_cnt >= QCNT_W'(7))
      else $error("qualification count lags the current");
   trip_fast_a: assert property (over150 |=> trip_150)
      else $error("150 percent trip late");
   phase_oc_a: assert property (!soft_start |=> phase_oc == '0)
      else $error("phase overcurrent outside soft-start");
   timer_reset_a: assert property (!over10 |=> qual_cnt == '0 ##0 !trip_100)
      else $error("qualification timer not restarted");
   irq_level_a: assert property (|(status & mask) |=> irq) else $error("interrupt missing");
   latch_step_a: assert property (latch_edge |=> latch_seen)
      else $error("strap source still on after latch");
   latch_copy_a: assert property (latch_edge |=> main_addr == $past(sres.main_addr)
                                  && aux_addr == $past(sres.aux_addr))
      else $error("latched address not passed on");
   src_hold_a: assert property (latched_d |-> !strap_source_en)
      else $error("strap source back on after latch");
   state_stay_a: assert property (latched_d |=> sres.latched)
      else $error("strap decoder left the latched state");
   trip150_drop_a: assert property (!over150 |=> !trip_150)
      else $error("150 percent trip held without current");
   trip100_hold_a: assert property (trip_100 && over10 |=> trip_100)
      else $error("100 percent trip dropped under load");
   trip_order_a: assert property (trip_100 && !over10 |=> !trip_100)
      else $error("100 percent trip held after the current fell");
   qual_bound_a: assert property (qual_cnt <= QCNT_W'(QUAL_CYC))
      else $error("qualification count past its end");
   irq_clear_a: assert property (!(|(status & mask)) |=> !irq)
      else $error("interrupt without a pending event");
   status_set_a: assert property (|events |=> (status & $past(events)) == $past(events))
      else $error("event lost against a clear");

   for (genvar p = 0; p < PHASES; p++) begin : g_phase_chk
      phase_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
         phase_sense_positive[p*8 +: 8] <= phase_sense_negative[p*8 +: 8] |=> !phase_oc[p])
         else $error("phase tripped without a positive difference");
   end

   // ==========================================================
   // Bus handshake checks
   wr_answer_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
                                 && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rd_answer_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
                                 && $stable(s_axi_rdata))
      else $error("read data dropped early");
   rd_turn_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write accepted while a response waits");
endmodule : rail_strap_limit
`default_nettype wire

// file: rail_strap_limit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rail_strap_limit_tb
   import strap_pkg::*;
;
   // ==========================================================
   // Stimulus and observed signals
   logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic                 awready, wready, bvalid, arready, rvalid, src_en, aux_en;
   logic                 aux_boot_strap, soft_start, trip_100, trip_150, irq;
   logic [7:0]           awaddr, araddr, strap_kohm, strap_pin, limit_i, lfsr;
   logic [31:0]          wdata, rdata;
   logic [3:0]           wstrb, main_addr, aux_addr;
   logic [1:0]           bresp, rresp;
   logic [PHASES*8-1:0]  pos, neg;
   logic [PHASES-1:0]    phase_oc;
   int                   errors, samples_checked;
   int                   dual_r[7]   = '{10, 25, 45, 70, 95, 125, 165};
   int                   single_r[9] = '{10, 22, 36, 51, 68, 91, 120, 160, 220};

   rail_strap_limit rail_strap_limit_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .address_strap_pin(strap_pin), .aux_boot_strap(aux_boot_strap),
      .strap_source_en(src_en), .limit_sense_current(limit_i), .soft_start(soft_start),
      .phase_sense_positive(pos), .phase_sense_negative(neg),
      .main_addr(main_addr), .aux_addr(aux_addr), .aux_enabled(aux_en),
      .trip_100(trip_100), .trip_150(trip_150), .phase_oc(phase_oc), .irq(irq)
   );

   strap_partner strap_partner_inst (
      .source_en(src_en), .strap_kohm(strap_kohm), .pin_code(strap_pin)
   );

   always #20 aclk = ~aclk;

   // ==========================================================
   // Shared tasks
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons=%0d mismatches=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask : tick

   // Each channel is released at the edge where its own ready is seen.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            resp = bresp;
            break;
         end
      end
      if (n == 200) begin
         errors++;
         complete_run();
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            d = rdata;
            resp = rresp;
            break;
         end
      end
      if (n == 200) begin
         errors++;
         complete_run();
      end
   endtask : axi_rd

   // ==========================================================
   // Trip reference
   // Whole cycles above the threshold are counted in an integer, from the rules alone.
   int   run_len;
   logic exp_t100;
   logic exp_t150;
   always @(posedge aclk) begin
      if (!aresetn) begin
         run_len  <= 0;
         exp_t100 <= 1'b0;
         exp_t150 <= 1'b0;
      end else begin
         check(32'(trip_100), 32'(exp_t100));
         check(32'(trip_150), 32'(exp_t150));
         run_len  <= (limit_i > LIM100_UA) ? run_len + 1 : 0;
         exp_t100 <= (limit_i > LIM100_UA) && (run_len + 1 >= QUAL_CYC);
         exp_t150 <= limit_i > LIM150_UA;
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0]        d;
      logic [1:0]         r;
      logic [7:0]         pv, nv;
      logic [PHASES-1:0]  exp_oc;
      int                 n;
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF; strap_kohm = 8'h0A; limit_i = 0;
      aux_boot_strap = 0; soft_start = 0; pos = 0; neg = 0; lfsr = 8'h44;
      errors = 0; samples_checked = 0;
      // Every strap value of both tables; the decode is only seen after a fresh start-up.
      for (int k = 0; k < 16; k++) begin
         logic sgl;
         int   idx;
         sgl = (k >= 7);
         idx = sgl ? k - 7 : k;
         aresetn        <= 1'b0;
         aux_boot_strap <= sgl;
         strap_kohm     <= 8'(sgl ? single_r[idx] : dual_r[idx]);
         tick(12);
         aresetn <= 1'b1;
         check(32'(src_en), 32'h1);
         for (n = 0; n < 3000 && src_en; n++) @(posedge aclk);
         if (n == 3000) begin
            errors++;
            complete_run();
         end
         strap_kohm <= 8'hFF;
         tick(3);
         check(32'(main_addr), 32'(sgl ? idx : 2 * idx));
         check(32'(aux_en), 32'(!sgl));
         if (!sgl) check(32'(aux_addr), 32'(2 * idx + 1));
         axi_rd(ADDR_INFO, d, r);
         check(d & (sgl ? 32'h70F : 32'h7FF),
               32'((!sgl << 10) | (sgl << 9) | 256 | (sgl ? idx : (2 * idx + 1) * 16 + 2 * idx)));
      end
      $display("strap sweep done");
      axi_rd(OC_LIMIT, d, r);
      check(d, 32'h40);
      axi_wr(OC_LIMIT, 32'h20, r);
      check(32'(r), 32'(RESP_OKAY));
      axi_rd(8'h20, d, r);
      check({d[29:0], r}, {30'h0, RESP_SLV});
      $display("register test done");
      // A dip to the threshold one cycle long must restart the qualification count.
      limit_i <= LIM100_UA + 8'h01;
      tick(1200);
      limit_i <= LIM100_UA;
      tick(1);
      limit_i <= LIM100_UA + 8'h01;
      tick(1200);
      check(32'(trip_100), 32'h0);
      for (n = 0; n < 100 && !trip_100; n++) @(posedge aclk);
      check(32'(n >= 49 && n <= 53), 32'h1);
      limit_i <= LIM100_UA;
      tick(2);
      check(32'(trip_100), 32'h0);
      for (int i = 0; i < 24; i++) begin
         lfsr = lfsr_next(lfsr);
         limit_i <= lfsr & 8'h1F;
         tick(2);
         check(32'(trip_150), 32'((lfsr & 8'h1F) > LIM150_UA));
      end
      limit_i <= 8'h00;
      $display("current limit test done");
      for (int i = 0; i < 16; i++) begin
         soft_start <= (i < 12);
         for (int p = 0; p < PHASES; p++) begin
            lfsr = lfsr_next(lfsr);
            pv = lfsr;
            lfsr = lfsr_next(lfsr);
            nv = lfsr & 8'h3F;
            pos[p*8+:8] <= pv;
            neg[p*8+:8] <= nv;
            exp_oc[p] = (i < 12) && pv > nv && (pv - nv) > 8'h20;
         end
         tick(2);
         check(32'(phase_oc), 32'(exp_oc));
      end
      soft_start <= 1'b0;
      $display("phase overcurrent test done");
      axi_rd(INT_STAT, d, r);
      check(d, 32'hF);
      axi_wr(INT_MASK, 32'h0, r);
      tick(2);
      check(32'(irq), 32'h0);
      axi_wr(INT_MASK, 32'h8, r);
      tick(2);
      check(32'(irq), 32'h1);
      axi_wr(INT_STAT, 32'hF, r);
      tick(2);
      check(32'(irq), 32'h0);
      axi_rd(INT_STAT, d, r);
      check(d, 32'h0);
      $display("interrupt test done");
      complete_run();
   end
endmodule : rail_strap_limit_tb
`default_nettype wire

// file: strap_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module strap_decoder
   import strap_pkg::*;
(
   // Clock and reset
   input  wire logic  aclk,
   input  wire logic  aresetn,
   // Strap pins
   input  wire logic  [7:0] strap_code,
   input  wire logic  aux_boot_strap,
   // Results
   strap_if.decoder   res
);
   strap_state_t      state;
   logic [SCNT_W-1:0] settle;

   // ==========================================================
   // Measurement and latch
   // The source current stays on only until the code is caught, so a later strap
   // change cannot disturb the latched address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state           <= ST_MEASURE;
         settle          <= '0;
         res.source_en   <= 1'b1;
         res.latched     <= 1'b0;
         res.single_mode <= 1'b0;
         res.main_addr   <= 4'h0;
         res.aux_addr    <= 4'h1;
      end else begin
         unique case (state)
            ST_MEASURE: begin
               res.source_en <= 1'b1;
               if (settle == SCNT_W'(SETTLE_CYC - 1)) begin
                  state           <= ST_LATCHED;
                  res.source_en   <= 1'b0;
                  res.latched     <= 1'b1;
                  res.single_mode <= aux_boot_strap;
                  res.main_addr   <= strap_decode(strap_code, aux_boot_strap);
                  res.aux_addr    <= strap_decode(strap_code, 1'b0) | 4'h1;
               end else begin
                  settle <= settle + SCNT_W'(1);
               end
            end
            ST_LATCHED: begin
               state <= ST_LATCHED;
            end
         endcase
      end
   end
endmodule : strap_decoder
`default_nettype wire

// file: strap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
   logic       source_en;
   logic       latched;
   logic       single_mode;
   logic [3:0] main_addr;
   logic [3:0] aux_addr;
   modport decoder (output source_en, latched, single_mode, main_addr, aux_addr);
   modport core (input source_en, latched, single_mode, main_addr, aux_addr);
endinterface : strap_if
`default_nettype wire

// file: strap_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Strap resistor to ground seen from the strap pin.
module strap_partner (
   // Source control
   input  wire logic       source_en,
   // Fitted resistor in kOhm
   input  wire logic [7:0] strap_kohm,
   // Pin voltage in 10 mV steps
   output logic      [7:0] pin_code
);
   // With the source off the resistor pulls the pin to ground, so a late read sees 0 V.
   assign pin_code = source_en ? strap_kohm : 8'h00;
endmodule : strap_partner
`default_nettype wire

// file: strap_pkg.sv
`default_nettype none
package strap_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ    = 25;
   localparam int SETTLE_US  = 100;
   localparam int QUAL_US    = 50;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   localparam int QUAL_CYC   = QUAL_US * CLK_MHZ;
   localparam int SCNT_W     = 12;
   localparam int QCNT_W     = 11;
   // ==========================================================
   // Strap and limit figures (strap code in 10 mV steps, current in 1 uA steps)
   localparam int         SOURCE_UA  = 10;
   localparam logic [7:0] LIM100_UA  = 8'h0A;
   localparam logic [7:0] LIM150_UA  = 8'h0F;
   localparam int         PHASES     = 5;
   localparam logic [7:0] DUAL_MID [6]   = '{8'h11, 8'h23, 8'h39, 8'h52, 8'h6E, 8'h91};
   localparam logic [7:0] SINGLE_MID [8] = '{8'h10, 8'h1D, 8'h2B, 8'h3B, 8'h4F, 8'h69,
                                             8'h8C, 8'hBE};
   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_INFO  = 8'h00;
   localparam logic [7:0] INT_STAT   = 8'h04;
   localparam logic [7:0] INT_MASK   = 8'h08;
   localparam logic [7:0] OC_LIMIT   = 8'h0C;
   localparam logic [7:0] LIVE_STAT  = 8'h10;
   localparam logic [7:0] OC_RESET   = 8'h40;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;
   localparam int EV_TRIP100 = 0;
   localparam int EV_TRIP150 = 1;
   localparam int EV_PHASEOC = 2;
   localparam int EV_LATCHED = 3;
   localparam int EV_W       = 4;

   typedef enum logic [0:0] {
      ST_MEASURE = 1'b0,
      ST_LATCHED = 1'b1
   } strap_state_t;

   function automatic logic [3:0] strap_decode(input logic [7:0] code, input logic single);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (single && code >= SINGLE_MID[i]) idx = idx + 4'h1;
      end
      for (int i = 0; i < 6; i++) begin
         if (!single && code >= DUAL_MID[i]) idx = idx + 4'h1;
      end
      return single ? idx : {idx[2:0], 1'b0};
   endfunction : strap_decode
endpackage : strap_pkg
`default_nettype wire
